/* common/sftc_pkg.sv */
// shared constants and types for the spi fifo threshold control block
package sftc_pkg;
  // register byte offsets
  localparam logic [7:0] SFTC_OFF_CTL = 8'h10;
  localparam logic [7:0] SFTC_OFF_STATUS = 8'h14;
  localparam logic [7:0] SFTC_OFF_MASK = 8'h18;
  localparam logic [7:0] SFTC_OFF_AUX = 8'h1c;
  // reset values
  localparam logic [31:0] SFTC_CTL_RESET = 32'h4400_0000;
  localparam logic [31:0] SFTC_MASK_RESET = 32'h000c_1c00;
  localparam logic [31:0] SFTC_IRQ_BITS = 32'h000c_1c00;
  // control register field positions
  localparam int SFTC_CTL_TX_THRESHOLD_LSB = 28;
  localparam int SFTC_CTL_RX_THRESHOLD_LSB = 24;
  localparam int SFTC_CTL_UR_IEN = 7;
  localparam int SFTC_CTL_UR_LVL = 6;
  localparam int SFTC_CTL_OV_IEN = 5;
  localparam int SFTC_CTL_TO_IEN = 4;
  localparam int SFTC_CTL_TX_THRESHOLD_IEN = 3;
  localparam int SFTC_CTL_RX_THRESHOLD_IEN = 2;
  localparam int SFTC_CTL_TXCLR = 1;
  localparam int SFTC_CTL_RXCLR = 0;
  // status register field positions (mask shares the layout)
  localparam int SFTC_ST_TXCNT_LSB = 28;
  localparam int SFTC_ST_RXCNT_LSB = 24;
  localparam int SFTC_ST_BUSY = 23;
  localparam int SFTC_ST_UR = 19;
  localparam int SFTC_ST_TX_THRESHOLD = 18;
  localparam int SFTC_ST_TX_FULL_FLAG = 17;
  localparam int SFTC_ST_TX_EMPTY_FLAG = 16;
  localparam int SFTC_ST_TO = 12;
  localparam int SFTC_ST_OV = 11;
  localparam int SFTC_ST_RX_THRESHOLD = 10;
  localparam int SFTC_ST_RX_FULL_FLAG = 9;
  localparam int SFTC_ST_RX_EMPTY_FLAG = 8;
  localparam int SFTC_AUX_TOCLR = 0;
  // clear sequence timing: system cycles then engine ticks
  localparam logic [1:0] SFTC_CLR_SYS_CYCLES = 2'h3;
  localparam logic [1:0] SFTC_CLR_ENG_TICKS = 2'h3;
  localparam int SFTC_ENG_DIV = 2;
  localparam int SFTC_FIFO_DEPTH = 4;

  // software-written control fields
  typedef struct packed {
    logic [1:0] tx_threshold;
    logic [1:0] rx_threshold;
    logic tx_underrun_irq_en;
    logic underrun_out_level;
    logic rx_overrun_irq_en;
    logic rx_timeout_irq_en;
    logic tx_threshold_irq_en;
    logic rx_threshold_irq_en;
  } sftc_ctl_t;

  // fill levels reported by the two fifos
  typedef struct packed {
    logic [3:0] tx_count;
    logic [3:0] rx_count;
  } sftc_level_t;

  typedef enum logic [1:0] {CLR_IDLE, CLR_SYS, CLR_ENG} sftc_clr_state_t;
endpackage

/* core/sftc_clear_seq.sv */
// self-clearing fifo clear sequencer: fixed system cycles then engine ticks
`timescale 1ns/1ps
module sftc_clear_seq import sftc_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic start,
  input wire logic eng_tick,
  output logic busy,
  output logic flush
);
  sftc_clr_state_t state_q, state_d;
  logic [1:0] cnt_q, cnt_d;
  logic flush_q;

  // a start while busy is absorbed; the running clear already empties the fifo
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      CLR_IDLE: begin
        if (start) begin
          state_d = CLR_SYS;
          cnt_d = SFTC_CLR_SYS_CYCLES;
        end
      end
      CLR_SYS: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = CLR_ENG;
          cnt_d = SFTC_CLR_ENG_TICKS;
        end
      end
      CLR_ENG: begin
        if (eng_tick) begin
          cnt_d = cnt_q - 2'h1;
          if (cnt_q == 2'h1) begin
            state_d = CLR_IDLE;
          end
        end
      end
    endcase
  end

  // state, count and the one-cycle flush strobe
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      state_q <= CLR_IDLE;
      cnt_q <= 2'h0;
      flush_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      flush_q <= start && (state_q == CLR_IDLE);
    end
  end

  assign busy = (state_q != CLR_IDLE);
  assign flush = flush_q;
endmodule

/* core/sftc_top.sv */
// spi fifo threshold, interrupt enable, under-run and clear control with ahb-lite registers
//
// Our own choice: register access over AHB-Lite.
`timescale 1ns/1ps
module sftc_top import sftc_pkg::*; #(
  parameter int DEPTH = SFTC_FIFO_DEPTH,
  parameter int ENG_DIV = SFTC_ENG_DIV
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire sftc_level_t fifo_level,
  input wire logic rx_write_req,
  input wire logic rx_timeout,
  input wire logic slave_mode,
  input wire logic slave_sel_active,
  input wire logic sclk_pin,
  input wire logic tx_bit,
  output logic slave_data_out,
  output logic tx_fifo_flush,
  output logic rx_fifo_flush,
  output logic tx_threshold_flag,
  output logic rx_threshold_flag,
  output logic tx_full_flag,
  output logic tx_empty_flag,
  output logic rx_full_flag,
  output logic rx_empty_flag,
  output logic irq
);
  localparam int CLR_WAIT = 4 * ENG_DIV + 4;
  localparam logic [3:0] FULL_CNT = 4'(DEPTH);

  sftc_ctl_t ctl_q, ctl_d;
  logic [31:0] status_q, status_d;
  logic [31:0] mask_q;
  logic timeout_auto_clear_en;
  logic dp_wr_q, dp_rd_q;
  logic [7:0] dp_addr_q;
  logic [31:0] hrdata_q;
  logic [31:0] rd_ctl, rd_status, rd_mux;
  logic [31:0] ev_set, en_vec;
  logic [1:0] clr_start, clr_busy, clr_flush;
  logic [$clog2(ENG_DIV+1)-1:0] div_q;
  logic eng_tick;
  logic sclk_s1, sclk_s2, sclk_s3, sclk_lvl_q;
  logic underrun_q, data_out_q;

  // ahb-lite address phase decode
  wire addr_take = hsel && htrans[1] && hready;
  wire word_ok = (hsize == 3'h2);
  wire wr_ctl = dp_wr_q && (dp_addr_q == SFTC_OFF_CTL);
  wire wr_status = dp_wr_q && (dp_addr_q == SFTC_OFF_STATUS);
  wire wr_mask = dp_wr_q && (dp_addr_q == SFTC_OFF_MASK);
  wire wr_aux = dp_wr_q && (dp_addr_q == SFTC_OFF_AUX);

  // capture the address phase; non-word writes are dropped but still answer okay
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      dp_wr_q <= 1'b0;
      dp_rd_q <= 1'b0;
      dp_addr_q <= 8'h00;
    end else begin
      dp_wr_q <= addr_take && hwrite && word_ok;
      dp_rd_q <= addr_take && !hwrite;
      if (addr_take) begin
        dp_addr_q <= {haddr[7:2], 2'b00};
      end
    end
  end

  // one wait state on reads so a write just before is already visible
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata_q <= 32'h0000_0000;
    end else if (dp_rd_q) begin
      hrdata_q <= rd_mux;
    end
  end

  assign hreadyout = !dp_rd_q;
  assign hresp = 1'b0;
  assign hrdata = hrdata_q;

  // control register next value
  always_comb begin
    ctl_d = ctl_q;
    if (wr_ctl) begin
      ctl_d.tx_threshold = hwdata[SFTC_CTL_TX_THRESHOLD_LSB +: 2];
      ctl_d.rx_threshold = hwdata[SFTC_CTL_RX_THRESHOLD_LSB +: 2];
      ctl_d.tx_underrun_irq_en = hwdata[SFTC_CTL_UR_IEN];
      ctl_d.underrun_out_level = hwdata[SFTC_CTL_UR_LVL];
      ctl_d.rx_overrun_irq_en = hwdata[SFTC_CTL_OV_IEN];
      ctl_d.rx_timeout_irq_en = hwdata[SFTC_CTL_TO_IEN];
      ctl_d.tx_threshold_irq_en = hwdata[SFTC_CTL_TX_THRESHOLD_IEN];
      ctl_d.rx_threshold_irq_en = hwdata[SFTC_CTL_RX_THRESHOLD_IEN];
    end
  end

  // software registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      ctl_q <= '0;
      mask_q <= SFTC_MASK_RESET;
      timeout_auto_clear_en <= 1'b0;
    end else begin
      ctl_q <= ctl_d;
      if (wr_mask) begin
        mask_q <= hwdata & SFTC_IRQ_BITS;
      end
      if (wr_aux) begin
        timeout_auto_clear_en <= hwdata[SFTC_AUX_TOCLR];
      end
    end
  end

  // engine-rate enable pulse; the clear sequence counts these
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      div_q <= '0;
    end else if (eng_tick) begin
      div_q <= '0;
    end else begin
      div_q <= div_q + 1'b1;
    end
  end

  assign eng_tick = (div_q == ($clog2(ENG_DIV+1))'(ENG_DIV - 1));

  // clear starts: a written one, or a time-out with auto-clear; zero does nothing
  wire auto_clr = rx_timeout && timeout_auto_clear_en;
  assign clr_start[1] = (wr_ctl && hwdata[SFTC_CTL_TXCLR]) || auto_clr;
  assign clr_start[0] = (wr_ctl && hwdata[SFTC_CTL_RXCLR]) || auto_clr;

  // one sequencer per fifo, index 1 tx and 0 rx
  for (genvar i = 0; i < 2; i++) begin : g_clr
    sftc_clear_seq u_seq (
      .hclk(hclk),
      .hresetn(hresetn),
      .start(clr_start[i]),
      .eng_tick(eng_tick),
      .busy(clr_busy[i]),
      .flush(clr_flush[i])
    );
  end

  assign tx_fifo_flush = clr_flush[1];
  assign rx_fifo_flush = clr_flush[0];

  // fifo indicators, forced to the empty state while a clear runs
  assign tx_full_flag = !clr_busy[1] && (fifo_level.tx_count == FULL_CNT);
  assign tx_empty_flag = clr_busy[1] || (fifo_level.tx_count == 4'h0);
  assign rx_full_flag = !clr_busy[0] && (fifo_level.rx_count == FULL_CNT);
  assign rx_empty_flag = clr_busy[0] || (fifo_level.rx_count == 4'h0);

  // threshold compares against the raw field value
  assign tx_threshold_flag = (fifo_level.tx_count <= {2'b00, ctl_q.tx_threshold});
  assign rx_threshold_flag = (fifo_level.rx_count > {2'b00, ctl_q.rx_threshold});

  // serial clock pin: three flops, level accepted once stages two and three agree
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      sclk_s1 <= 1'b0;
      sclk_s2 <= 1'b0;
      sclk_s3 <= 1'b0;
      sclk_lvl_q <= 1'b0;
    end else begin
      sclk_s1 <= sclk_pin;
      sclk_s2 <= sclk_s1;
      sclk_s3 <= sclk_s2;
      if (sclk_s2 == sclk_s3) begin
        sclk_lvl_q <= sclk_s3;
      end
    end
  end

  // the sync delay is why a few bits of old data still leave first
  wire sclk_edge = (sclk_s3 == sclk_s2) && sclk_s3 && !sclk_lvl_q;
  wire in_xfer = slave_mode && slave_sel_active;
  wire ur_event = in_xfer && sclk_edge && tx_empty_flag;

  // under-run state and data out register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      underrun_q <= 1'b0;
      data_out_q <= 1'b0;
    end else begin
      if (ur_event) begin
        underrun_q <= 1'b1;
      end else if (!in_xfer || !tx_empty_flag) begin
        underrun_q <= 1'b0;
      end
      data_out_q <= underrun_q ? ctl_q.underrun_out_level : tx_bit;
    end
  end

  assign slave_data_out = data_out_q;

  // event set vector and enable vector in status layout
  wire rx_overrun = rx_write_req && rx_full_flag;
  always_comb begin
    ev_set = 32'h0000_0000;
    ev_set[SFTC_ST_UR] = ur_event;
    ev_set[SFTC_ST_TX_THRESHOLD] = tx_threshold_flag;
    ev_set[SFTC_ST_TO] = rx_timeout;
    ev_set[SFTC_ST_OV] = rx_overrun;
    ev_set[SFTC_ST_RX_THRESHOLD] = rx_threshold_flag;
    en_vec = 32'h0000_0000;
    en_vec[SFTC_ST_UR] = ctl_q.tx_underrun_irq_en;
    en_vec[SFTC_ST_TX_THRESHOLD] = ctl_q.tx_threshold_irq_en;
    en_vec[SFTC_ST_TO] = ctl_q.rx_timeout_irq_en;
    en_vec[SFTC_ST_OV] = ctl_q.rx_overrun_irq_en;
    en_vec[SFTC_ST_RX_THRESHOLD] = ctl_q.rx_threshold_irq_en;
  end

  // sticky status: write one clears, a same-cycle event wins
  wire [31:0] w1c = wr_status ? hwdata : 32'h0000_0000;
  assign status_d = ((status_q & ~w1c) | ev_set) & SFTC_IRQ_BITS;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      status_q <= 32'h0000_0000;
    end else begin
      status_q <= status_d;
    end
  end

  // single level request; levels re-set their bit so clearing only sticks once they drop
  assign irq = |(status_q & mask_q & en_vec);

  // read images
  always_comb begin
    rd_ctl = SFTC_CTL_RESET & 32'h4400_0000;
    rd_ctl[SFTC_CTL_TX_THRESHOLD_LSB +: 2] = ctl_q.tx_threshold;
    rd_ctl[SFTC_CTL_RX_THRESHOLD_LSB +: 2] = ctl_q.rx_threshold;
    rd_ctl[SFTC_CTL_UR_IEN] = ctl_q.tx_underrun_irq_en;
    rd_ctl[SFTC_CTL_UR_LVL] = ctl_q.underrun_out_level;
    rd_ctl[SFTC_CTL_OV_IEN] = ctl_q.rx_overrun_irq_en;
    rd_ctl[SFTC_CTL_TO_IEN] = ctl_q.rx_timeout_irq_en;
    rd_ctl[SFTC_CTL_TX_THRESHOLD_IEN] = ctl_q.tx_threshold_irq_en;
    rd_ctl[SFTC_CTL_RX_THRESHOLD_IEN] = ctl_q.rx_threshold_irq_en;
    rd_ctl[SFTC_CTL_TXCLR] = clr_busy[1];
    rd_ctl[SFTC_CTL_RXCLR] = clr_busy[0];
    rd_status = status_q;
    rd_status[SFTC_ST_TXCNT_LSB +: 4] = fifo_level.tx_count;
    rd_status[SFTC_ST_RXCNT_LSB +: 4] = fifo_level.rx_count;
    rd_status[SFTC_ST_BUSY] = |clr_busy;
    rd_status[SFTC_ST_TX_FULL_FLAG] = tx_full_flag;
    rd_status[SFTC_ST_TX_EMPTY_FLAG] = tx_empty_flag;
    rd_status[SFTC_ST_RX_FULL_FLAG] = rx_full_flag;
    rd_status[SFTC_ST_RX_EMPTY_FLAG] = rx_empty_flag;
  end

  // unmapped offsets read as zero
  assign rd_mux = (dp_addr_q == SFTC_OFF_CTL) ? rd_ctl :
                  (dp_addr_q == SFTC_OFF_STATUS) ? rd_status :
                  (dp_addr_q == SFTC_OFF_MASK) ? mask_q :
                  (dp_addr_q == SFTC_OFF_AUX) ? {31'h0000_0000, timeout_auto_clear_en} :
                  32'h0000_0000;

  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);

  txthr_flag_a: assert property (tx_threshold_flag |-> fifo_level.tx_count <= {2'b00, ctl_q.tx_threshold})
    else $error("tx threshold flag high above threshold");
  rxthr_flag_a: assert property (rx_threshold_flag == (fifo_level.rx_count > {2'b00, ctl_q.rx_threshold}))
    else $error("rx threshold flag wrong");
  txclr_empty_a: assert property (clr_start[1] |=> (tx_empty_flag && !tx_full_flag)[*3])
    else $error("tx fifo not shown empty during clear");
  rxclr_empty_a: assert property (clr_start[0] |=> (rx_empty_flag && !rx_full_flag)[*3])
    else $error("rx fifo not shown empty during clear");
  clr_selfclr_a: assert property ($rose(clr_busy[1]) |-> (clr_busy[1])[*3] ##[1:CLR_WAIT] !clr_busy[1])
    else $error("tx clear bit length wrong");
  auto_clear_a: assert property (auto_clr |=> clr_busy == 2'b11)
    else $error("time-out auto clear missed");
  txthr_irq_a: assert property (tx_threshold_flag && ctl_q.tx_threshold_irq_en && mask_q[SFTC_ST_TX_THRESHOLD] |=> irq)
    else $error("tx threshold interrupt missing");
  underrun_set_a: assert property (ur_event |=> status_q[SFTC_ST_UR] ##1 (status_q[SFTC_ST_UR] || $past(wr_status)))
    else $error("under-run flag not set");
  clr_busy_a: assert property (clr_start[0] && !clr_busy[0] |=> (rd_status[SFTC_ST_BUSY])[*3])
    else $error("clear busy status low while clearing");
  irq_gate_a: assert property (irq |-> |(status_q & en_vec))
    else $error("interrupt without enabled flag");
  ur_level_a: assert property (underrun_q |=> slave_data_out == $past(ctl_q.underrun_out_level))
    else $error("under-run data level wrong");
endmodule

/* dv/sftc_engine_model.sv */
// behavioural fifo and serial clock stand-in for the engine side of the block
`timescale 1ns/1ps
module sftc_engine_model import sftc_pkg::*; (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic load,
  input wire logic [3:0] tx_set,
  input wire logic [3:0] rx_set,
  input wire logic sclk_run,
  input wire logic tx_fifo_flush,
  input wire logic rx_fifo_flush,
  output sftc_level_t fifo_level,
  output logic sclk_pin,
  output logic tx_bit
);
  logic [2:0] div_q;

  // counts follow the bench; a flush empties that fifo as real storage would
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      fifo_level <= '0;
      div_q <= 3'h0;
      sclk_pin <= 1'b0;
      tx_bit <= 1'b0;
    end else begin
      tx_bit <= ~tx_bit; // changes every cycle so stale data shows
      div_q <= div_q + 3'h1;
      sclk_pin <= sclk_run & div_q[2]; // stands low outside frames
      if (load) begin
        fifo_level <= {tx_set, rx_set};
      end
      if (tx_fifo_flush) begin
        fifo_level.tx_count <= 4'h0;
      end
      if (rx_fifo_flush) begin
        fifo_level.rx_count <= 4'h0;
      end
    end
  end
endmodule

/* dv/sftc_top_bench.sv */
// self-checking bench for the fifo threshold control block
`timescale 1ns/1ps
module sftc_top_bench import sftc_pkg::*;;
  logic hclk, hresetn, hsel, hwrite, rx_write_req, rx_timeout, slave_mode, slave_sel_active, load, sclk_run;
  logic sclk_pin, tx_bit, hreadyout, hresp, slave_data_out, tx_fifo_flush, rx_fifo_flush, irq;
  logic tx_threshold_flag, rx_threshold_flag, tx_full_flag, tx_empty_flag, rx_full_flag, rx_empty_flag;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [3:0] tx_set, rx_set;
  sftc_level_t fifo_level;
  int num_errors = 0;
  int checked = 0;

  // slower engine ticks keep the clear busy window wide enough to read twice
  sftc_top #(.ENG_DIV(4)) sftc_top_i (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .fifo_level(fifo_level),
    .rx_write_req(rx_write_req), .rx_timeout(rx_timeout), .slave_mode(slave_mode),
    .slave_sel_active(slave_sel_active), .sclk_pin(sclk_pin), .tx_bit(tx_bit),
    .slave_data_out(slave_data_out), .tx_fifo_flush(tx_fifo_flush), .rx_fifo_flush(rx_fifo_flush),
    .tx_threshold_flag(tx_threshold_flag), .rx_threshold_flag(rx_threshold_flag),
    .tx_full_flag(tx_full_flag), .tx_empty_flag(tx_empty_flag), .rx_full_flag(rx_full_flag),
    .rx_empty_flag(rx_empty_flag), .irq(irq));
  sftc_engine_model sftc_engine_model_i (.hclk(hclk), .hresetn(hresetn), .load(load), .tx_set(tx_set),
    .rx_set(rx_set), .sclk_run(sclk_run), .tx_fifo_flush(tx_fifo_flush), .rx_fifo_flush(rx_fifo_flush),
    .fifo_level(fifo_level), .sclk_pin(sclk_pin), .tx_bit(tx_bit));

  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask

  // sample where settled, one half period ahead of the edge that takes it
  task automatic wait_ready();
    int n;
    n = 0;
    @(negedge hclk);
    while (hreadyout !== 1'b1 && n < 50) begin
      n++;
      @(negedge hclk);
    end
    if (n == 50) begin
      num_errors++;
      report_and_stop();
    end
    rd = hrdata;
    @(posedge hclk);
  endtask

  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h00_0000, a};
    hwrite <= w;
    wait_ready();
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    wait_ready();
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask

  task automatic rdc(input string nm, input logic [7:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk(nm, exp, rd);
  endtask

  task automatic set_lvl(input logic [3:0] t, input logic [3:0] r);
    @(posedge hclk);
    load <= 1'b1;
    tx_set <= t;
    rx_set <= r;
    @(posedge hclk);
    load <= 1'b0;
    repeat (2) @(posedge hclk);
    @(negedge hclk);
  endtask

  task automatic pulse(input int k);
    @(posedge hclk);
    if (k != 0) begin
      rx_timeout <= 1'b1;
    end else begin
      rx_write_req <= 1'b1;
    end
    @(posedge hclk);
    rx_timeout <= 1'b0;
    rx_write_req <= 1'b0;
  endtask

  // event already latched: enable off keeps irq low, enable on raises it
  task automatic irq_on(input int en, input int st);
    wr(SFTC_OFF_CTL, 32'h0);
    @(negedge hclk);
    chk("irq disabled", 32'h0, irq);
    bus(1'b0, SFTC_OFF_STATUS, 32'h0);
    chk("sticky set", 32'h1, rd[st]);
    wr(SFTC_OFF_CTL, 32'(1) << en);
    @(negedge hclk);
    chk("irq enabled", 32'h1, irq);
  endtask

  task automatic irq_off(input int st);
    wr(SFTC_OFF_STATUS, 32'(1) << st);
    bus(1'b0, SFTC_OFF_STATUS, 32'h0);
    chk("sticky cleared", 32'h0, rd[st]);
    @(negedge hclk);
    chk("irq cleared", 32'h0, irq);
  endtask

  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end

  initial begin
    {hsel, hwrite, rx_write_req, rx_timeout, slave_mode, slave_sel_active, load, sclk_run} = '0;
    {htrans, haddr, hwdata, tx_set, rx_set} = '0;
    hsize = 3'h2;
    hresetn = 1'b0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    rdc("ctl reset", SFTC_OFF_CTL, SFTC_CTL_RESET);
    rdc("mask reset", SFTC_OFF_MASK, SFTC_MASK_RESET);
    wr(8'h20, 32'hffff_ffff);
    rdc("unmapped", 8'h20, 32'h0);
    chk("okay response", 32'h0, hresp);
    // a byte-sized write must leave the control register alone
    @(posedge hclk);
    hsize <= 3'h0;
    wr(SFTC_OFF_CTL, 32'h0000_00fc);
    @(posedge hclk);
    hsize <= 3'h2;
    rdc("byte write ignored", SFTC_OFF_CTL, SFTC_CTL_RESET);
    $display("test reset values done");
    // every threshold code against every fill level, both boundaries
    for (int t = 0; t < 4; t++) begin
      wr(SFTC_OFF_CTL, (t << 28) | (t << 24));
      rdc("ctl thresholds", SFTC_OFF_CTL, SFTC_CTL_RESET | (t << 28) | (t << 24));
      for (int c = 0; c <= 4; c++) begin
        set_lvl(c[3:0], c[3:0]);
        chk("tx threshold flag", 32'(c <= t), tx_threshold_flag);
        chk("rx threshold flag", 32'(c > t), rx_threshold_flag);
        chk("tx full", 32'(c == 4), tx_full_flag);
        chk("rx empty", 32'(c == 0), rx_empty_flag);
      end
    end
    $display("test thresholds done");
    set_lvl(4'h1, 4'h0);
    wr(SFTC_OFF_STATUS, SFTC_IRQ_BITS);
    set_lvl(4'h0, 4'h0);
    irq_on(SFTC_CTL_TX_THRESHOLD_IEN, SFTC_ST_TX_THRESHOLD);
    set_lvl(4'h1, 4'h0);
    irq_off(SFTC_ST_TX_THRESHOLD);
    set_lvl(4'h1, 4'h1);
    irq_on(SFTC_CTL_RX_THRESHOLD_IEN, SFTC_ST_RX_THRESHOLD);
    wr(SFTC_OFF_MASK, 32'h0);
    @(negedge hclk);
    chk("masked irq", 32'h0, irq);
    wr(SFTC_OFF_MASK, SFTC_MASK_RESET);
    set_lvl(4'h1, 4'h0);
    irq_off(SFTC_ST_RX_THRESHOLD);
    set_lvl(4'h1, 4'h4);
    pulse(0);
    irq_on(SFTC_CTL_OV_IEN, SFTC_ST_OV);
    set_lvl(4'h1, 4'h0);
    irq_off(SFTC_ST_OV);
    pulse(1);
    irq_on(SFTC_CTL_TO_IEN, SFTC_ST_TO);
    irq_off(SFTC_ST_TO);
    $display("test interrupts done");
    // slave under-run: empty tx fifo while the serial clock keeps running
    @(posedge hclk);
    slave_mode <= 1'b1;
    slave_sel_active <= 1'b1;
    set_lvl(4'h0, 4'h0);
    @(posedge hclk);
    sclk_run <= 1'b1;
    repeat (40) @(posedge hclk);
    for (int v = 0; v < 2; v++) begin
      wr(SFTC_OFF_CTL, 32'(v) << 6);
      repeat (3) @(posedge hclk);
      for (int n = 0; n < 4; n++) begin
        @(negedge hclk);
        chk("under-run level", 32'(v), slave_data_out);
      end
    end
    irq_on(SFTC_CTL_UR_IEN, SFTC_ST_UR);
    @(posedge hclk);
    sclk_run <= 1'b0;
    slave_sel_active <= 1'b0;
    set_lvl(4'h1, 4'h0);
    irq_off(SFTC_ST_UR);
    $display("test under-run done");
    // clear of one fifo leaves the other untouched, then self-clears
    for (int i = 0; i < 2; i++) begin
      set_lvl(4'h4, 4'h4);
      wr(SFTC_OFF_CTL, 32'h2 >> i);
      bus(1'b0, SFTC_OFF_CTL, 32'h0);
      chk("clear bit busy", 32'h1, rd[1 - i]);
      // threshold sticky bits stand again, re-set by the fill levels after irq_off cleared them
      rdc("busy status", SFTC_OFF_STATUS, i == 0 ? 32'h0485_0600 : 32'h4086_0500);
      @(negedge hclk);
      chk("cleared fifo empty", 32'h1, i == 0 ? tx_empty_flag : rx_empty_flag);
      chk("cleared fifo not full", 32'h0, i == 0 ? tx_full_flag : rx_full_flag);
      chk("other fifo kept", 32'h1, i == 0 ? rx_full_flag : tx_full_flag);
      for (int n = 0; n < 20 && rd[23] !== 1'b0; n++) begin
        bus(1'b0, SFTC_OFF_STATUS, 32'h0);
      end
      chk("clear done", 32'h0, rd[23]);
      if (rd[23] !== 1'b0) begin
        report_and_stop();
      end
      rdc("clear bit returned", SFTC_OFF_CTL, SFTC_CTL_RESET);
    end
    $display("test fifo clear done");
    wr(SFTC_OFF_AUX, 32'h1);
    set_lvl(4'h4, 4'h4);
    pulse(1);
    @(posedge hclk);
    @(negedge hclk);
    chk("auto clear tx", 32'h1, tx_empty_flag);
    chk("auto clear rx", 32'h1, rx_empty_flag);
    $display("test auto clear done");
    report_and_stop();
  end
endmodule
